// ### src/fif_pkg.sv
// Purpose: shared constants and helpers for the ingress frame filter
// Assumes: one 10 MHz clock, word-addressed register port
// Notes: entry and port settings are 16-bit words, low bits of the bus
package fif_pkg;
  // sizes
  localparam int NUM_PORTS = 10;
  localparam int NUM_ENT = 4;
  localparam int PORT_W = 4;
  localparam int ENT_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  // three-way flag condition codes (3 also reads as don't-care)
  localparam logic [1:0] COND_ZERO = 2'h0;
  localparam logic [1:0] COND_ONE = 2'h1;
  localparam logic [1:0] COND_ANY = 2'h2;
  // tcp flag positions in the frame flag vector
  localparam int FLAG_FIN = 0;
  localparam int FLAG_SYN = 1;
  localparam int FLAG_RST = 2;
  localparam int FLAG_PSH = 3;
  localparam int FLAG_ACK = 4;
  localparam int FLAG_URG = 5;
  // filter_entry config word fields
  localparam int ENT_VALID_BIT = 0;
  localparam int ENT_FTYPE_BIT = 1;
  localparam int ENT_SPEC_BIT = 2;
  localparam int ENT_DENY_BIT = 3;
  localparam int ENT_COND_LSB = 4;
  localparam logic [15:0] ENT_CFG_RST = 16'hAAA0;
  localparam logic [15:0] ENT_ETYPE_RST = 16'h0600;
  // per-port config word fields
  localparam int PC_GRP_LSB = 0;
  localparam int PC_DENY_BIT = 3;
  localparam int PC_RATE_LSB = 4;
  localparam int PC_COPY_EN_BIT = 8;
  localparam int PC_COPY_LSB = 9;
  localparam int PC_MIRROR_BIT = 13;
  localparam int PC_LOG_BIT = 14;
  localparam int PC_SHUT_BIT = 15;
  localparam logic [15:0] PORT_CFG_RST = 16'h0000;
  // register word addresses
  localparam logic [7:0] A_ENT_CFG = 8'h10;
  localparam logic [7:0] A_ENT_ETYPE = 8'h20;
  localparam logic [7:0] A_ENT_CNT = 8'h30;
  localparam logic [7:0] A_PORT_CFG = 8'h40;
  localparam logic [7:0] A_PORT_DIS = 8'h50;
  localparam logic [7:0] A_CLEAR = 8'h51;
  // ethertypes that belong to the ip classes, not the ethertype class
  localparam logic [15:0] ET_IPV4 = 16'h0800;
  localparam logic [15:0] ET_ARP = 16'h0806;
  localparam logic [15:0] ET_IPV6 = 16'h86DD;
  // log rate limit: least gap between two logged frames
  localparam int CLK_NS = 100;
  localparam int LOG_GAP_NS = 100000;
  localparam int LOG_GAP_CYC = LOG_GAP_NS / CLK_NS;
  localparam int LOG_CNT_W = 10;

  // two-bit condition k of an entry config word
  function automatic logic [1:0] fif_cond(input logic [15:0] cfg,
                                          input int k);
    fif_cond = cfg[ENT_COND_LSB + 2 * k +: 2];
  endfunction : fif_cond

  // one flag condition: don't-care, or tcp with the flag as asked
  function automatic logic fif_flag_ok(input logic [1:0] cond,
                                       input logic is_tcp,
                                       input logic flag);
    fif_flag_ok = cond[1] || (is_tcp && (flag == cond[0]));
  endfunction : fif_flag_ok
endpackage : fif_pkg

// ### src/fif_entry_match.sv
// Purpose: decide whether one frame matches one filter_entry
// Assumes: config words are stable while a frame is presented
// Notes: purely combinational, one instance per entry
module fif_entry_match
  import fif_pkg::*;
(
  input wire logic [15:0] cfg,
  input wire logic [15:0] etype_val,
  input wire logic is_tcp,
  input wire logic [5:0] tcp_flags,
  input wire logic [15:0] etype,
  output logic hit
);
  logic flags_ok; // all six flag tests pass
  logic type_ok; // frame-type and ethertype tests pass
  logic et_class; // frame is outside the ip ethertypes

  /////////////////////////////////////////////////////////////////////////
  // flag and type tests
  always_comb
  begin
    flags_ok = 1'b1;
    // fin, syn, rst, psh, ack, urg in that order
    for (int k = 0; k < 6; k++)
      flags_ok = flags_ok &&
        fif_flag_ok(fif_cond(cfg, k), is_tcp, tcp_flags[k]);
    et_class = (etype != ET_IPV4) && (etype != ET_ARP) && (etype != ET_IPV6);
    // ethertype value only counts for the ethertype class
    if (cfg[ENT_FTYPE_BIT])
      type_ok = et_class && (!cfg[ENT_SPEC_BIT] || etype == etype_val);
    else
      type_ok = 1'b1;
    hit = cfg[ENT_VALID_BIT] && flags_ok && type_ok;
  end
endmodule : fif_entry_match

// ### src/fif_log_gate.sv
// Purpose: rate limit for frames passed to the system log
// Assumes: log_req is a one-cycle request per frame
// Notes: grant is combinational so the frame result carries it at once
module fif_log_gate
  import fif_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic log_req,
  output logic log_grant
);
  typedef struct packed {
    logic [LOG_CNT_W-1:0] gap; // cycles left before next grant
  } fif_gate_t;
  fif_gate_t q, d;

  /////////////////////////////////////////////////////////////////////////
  // grant only when the gap has run out, then restart it
  always_comb
  begin
    d = q;
    log_grant = log_req && (q.gap == '0);
    if (log_grant)
      d.gap = LOG_CNT_W'(LOG_GAP_CYC - 1);
    else if (q.gap != '0)
      d.gap = q.gap - 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  // a grant is followed by a closed window
  property p_log_gap;
    @(posedge clk) disable iff (!resetn)
      log_grant |=> !log_grant [*8];
  endproperty
  a_log_gap: assert property (p_log_gap)
    else $error("log granted inside the rate gap");
endmodule : fif_log_gate

// ### src/fif_filter_top.sv
// Purpose: ingress frame filter and per-port policy for a switch
// Assumes: one frame descriptor per frm_valid pulse, synchronous inputs
// Notes: result of a frame appears one cycle after its descriptor

// Summary of operation
// - each entry holds three-way fin condition
// - each entry holds three-way syn condition
// - each entry holds three-way rst condition
// - each entry holds three-way psh condition
// - each entry holds three-way ack condition
// - each entry holds three-way urg condition
// - ethertype test only for ethertype class entries
// - ethertype filter is don't-care or exact
// - port deny, copy, mirror and log defaults apply unless an entry matches; group and rate always come from the port
// - port policy group 1..8, resets 1
// - port action permit or deny, resets permit
// - rate limiter off or 1..15, resets off
// - port copy off or target port
// - mirror received frames when enabled
// - log received frames when enabled, rate limited
// - shutdown disables port on any frame
// - per-entry hit counter, readable
// - clear command zeroes hit counters
module fif_filter_top
  import fif_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [fif_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fif_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fif_pkg::DATA_W-1:0] reg_rdata,
  input wire logic frm_valid,
  input wire logic [fif_pkg::PORT_W-1:0] frm_port,
  input wire logic frm_is_tcp,
  input wire logic [5:0] frm_tcp_flags,
  input wire logic [15:0] frm_etype,
  output logic res_valid,
  output logic res_hit,
  output logic [fif_pkg::ENT_W-1:0] res_entry,
  output logic res_deny,
  output logic [3:0] res_group,
  output logic [3:0] res_rate,
  output logic res_copy_en,
  output logic [fif_pkg::PORT_W-1:0] res_copy_port,
  output logic res_mirror,
  output logic res_log,
  output logic [fif_pkg::NUM_PORTS-1:0] port_dis
);
  import fif_pkg::*;

  /////////////////////////////////////////////////////////////////////////
  // state

  // all state of the block except the log gate counter in one word
  typedef struct packed {
    logic [NUM_ENT-1:0][15:0] ent_cfg; // filter_entry settings
    logic [NUM_ENT-1:0][15:0] ent_etype; // ethertype compare values
    logic [NUM_ENT-1:0][CNT_W-1:0] hit_cnt; // per-entry hit counters
    logic [NUM_PORTS-1:0][15:0] port_cfg; // per-port defaults
    logic [NUM_PORTS-1:0] port_dis; // ports shut down by a frame
    logic [DATA_W-1:0] rdata; // read data, valid one cycle
    logic res_valid; // result strobe
    logic res_hit; // an entry matched
    logic [ENT_W-1:0] res_entry; // index of the matching entry
    logic res_deny; // frame must be dropped
    logic [3:0] res_group; // port_policy_group, 1..8
    logic [3:0] res_rate; // rate_limiter_select, 0 is off
    logic res_copy_en; // duplicate to res_copy_port
    logic [PORT_W-1:0] res_copy_port; // copy target
    logic res_mirror; // send a copy to the mirror port
    logic res_log; // pass to the system log
  } fif_state_t;

  fif_state_t q, d;

  logic [NUM_ENT-1:0] ent_hit; // per-entry match of current frame
  logic log_req; // frame asks to be logged
  logic log_grant; // rate gate lets it through

  // true when addr lies in an entry bank starting at base
  function automatic logic in_bank(input logic [7:0] addr,
                                   input logic [7:0] base,
                                   input int count);
    in_bank = (addr[7:4] == base[7:4]) && (int'(addr[3:0]) < count);
  endfunction : in_bank

  /////////////////////////////////////////////////////////////////////////
  // matchers, one per filter_entry, all looking at the same frame
  for (genvar i = 0; i < NUM_ENT; i++)
  begin : g_ent
    fif_entry_match u_match (
      .cfg(q.ent_cfg[i]),
      .etype_val(q.ent_etype[i]),
      .is_tcp(frm_is_tcp),
      .tcp_flags(frm_tcp_flags),
      .etype(frm_etype),
      .hit(ent_hit[i])
    );
  end

  // logging is throttled so a flood cannot swamp the log path
  fif_log_gate u_log (
    .clk(clk),
    .resetn(resetn),
    .log_req(log_req),
    .log_grant(log_grant)
  );

  /////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic port_ok; // frame port exists
    logic any_hit; // at least one entry matched
    logic [ENT_W-1:0] win; // lowest matching entry
    logic [15:0] pc; // config of the receiving port
    logic [PORT_W-1:0] pidx; // receiving port, in range
    port_ok = 1'b0;
    any_hit = 1'b0;
    win = '0;
    pc = PORT_CFG_RST;
    pidx = '0;
    log_req = 1'b0;
    d = q;
    // res_valid, res_hit and res_log are strobes; clear them and rdata every cycle
    d.res_valid = 1'b0;
    d.res_hit = 1'b0;
    d.res_log = 1'b0;
    d.rdata = '0;

    // register writes
    if (reg_wr)
    begin
      if (in_bank(reg_addr, A_ENT_CFG, NUM_ENT))
        d.ent_cfg[reg_addr[ENT_W-1:0]] = reg_wdata[15:0];
      else if (in_bank(reg_addr, A_ENT_ETYPE, NUM_ENT))
        d.ent_etype[reg_addr[ENT_W-1:0]] = reg_wdata[15:0];
      else if (in_bank(reg_addr, A_PORT_CFG, NUM_PORTS))
        d.port_cfg[reg_addr[PORT_W-1:0]] = reg_wdata[15:0];
      else if (reg_addr == A_PORT_DIS)
        // write one to re-enable a port
        d.port_dis = q.port_dis & ~reg_wdata[NUM_PORTS-1:0];
      else if (reg_addr == A_CLEAR)
      begin
        // clear before counting so a same-cycle hit still counts
        for (int i = 0; i < NUM_ENT; i++)
          d.hit_cnt[i] = '0;
      end
    end

    // register reads, answered next cycle; unmapped reads give zero
    if (reg_rd)
    begin
      if (in_bank(reg_addr, A_ENT_CFG, NUM_ENT))
        d.rdata = {16'h0000, q.ent_cfg[reg_addr[ENT_W-1:0]]};
      else if (in_bank(reg_addr, A_ENT_ETYPE, NUM_ENT))
        d.rdata = {16'h0000, q.ent_etype[reg_addr[ENT_W-1:0]]};
      else if (in_bank(reg_addr, A_ENT_CNT, NUM_ENT))
        d.rdata = q.hit_cnt[reg_addr[ENT_W-1:0]];
      else if (in_bank(reg_addr, A_PORT_CFG, NUM_PORTS))
        d.rdata = {16'h0000, q.port_cfg[reg_addr[PORT_W-1:0]]};
      else if (reg_addr == A_PORT_DIS)
        d.rdata = {{(DATA_W - NUM_PORTS){1'b0}}, q.port_dis};
    end

    // frame classification
    if (frm_valid && int'(frm_port) < NUM_PORTS)
    begin
      port_ok = 1'b1;
      pidx = frm_port;
      pc = q.port_cfg[pidx];
      // lowest index wins when several entries match
      for (int i = NUM_ENT - 1; i >= 0; i--)
      begin
        if (ent_hit[i])
        begin
          any_hit = 1'b1;
          win = ENT_W'(i);
        end
      end
    end

    if (port_ok)
    begin
      d.res_valid = 1'b1;
      d.res_entry = win;
      d.res_group = 4'(pc[PC_GRP_LSB +: 3]) + 4'h1;
      d.res_rate = pc[PC_RATE_LSB +: 4];
      d.res_copy_port = pc[PC_COPY_LSB +: PORT_W];
      if (q.port_dis[pidx])
      begin
        // a shut port drops everything and has no side effects
        d.res_deny = 1'b1;
        d.res_copy_en = 1'b0;
        d.res_mirror = 1'b0;
      end
      else if (any_hit)
      begin
        // a matching entry overrides the port deny, copy, mirror and log defaults
        d.res_hit = 1'b1;
        d.res_deny = q.ent_cfg[win][ENT_DENY_BIT];
        d.res_copy_en = 1'b0;
        d.res_mirror = 1'b0;
        d.hit_cnt[win] = d.hit_cnt[win] + 1'b1;
      end
      else
      begin
        // port defaults
        d.res_deny = pc[PC_DENY_BIT];
        d.res_copy_en = pc[PC_COPY_EN_BIT];
        d.res_mirror = pc[PC_MIRROR_BIT];
        log_req = pc[PC_LOG_BIT];
        d.res_log = log_grant;
      end
      // any frame on a shutdown-enabled port disables it; set wins
      if (pc[PC_SHUT_BIT])
        d.port_dis[pidx] = 1'b1;
    end
  end

  /////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q.ent_cfg <= {NUM_ENT{ENT_CFG_RST}};
      q.ent_etype <= {NUM_ENT{ENT_ETYPE_RST}};
      q.hit_cnt <= '0;
      q.port_cfg <= {NUM_PORTS{PORT_CFG_RST}};
      q.port_dis <= '0;
      q.rdata <= '0;
      q.res_valid <= 1'b0;
      q.res_hit <= 1'b0;
      q.res_entry <= '0;
      q.res_deny <= 1'b0;
      q.res_group <= 4'h1;
      q.res_rate <= 4'h0;
      q.res_copy_en <= 1'b0;
      q.res_copy_port <= '0;
      q.res_mirror <= 1'b0;
      q.res_log <= 1'b0;
    end
    else
      q <= d;
  end

  // outputs straight from flip-flops
  assign reg_rdata = q.rdata;
  assign res_valid = q.res_valid;
  assign res_hit = q.res_hit;
  assign res_entry = q.res_entry;
  assign res_deny = q.res_deny;
  assign res_group = q.res_group;
  assign res_rate = q.res_rate;
  assign res_copy_en = q.res_copy_en;
  assign res_copy_port = q.res_copy_port;
  assign res_mirror = q.res_mirror;
  assign res_log = q.res_log;
  assign port_dis = q.port_dis;

  /////////////////////////////////////////////////////////////////////////
  // checks on entry 0 and the policy path
  property p_fin_zero;
    @(posedge clk) disable iff (!resetn)
      frm_is_tcp && frm_tcp_flags[FLAG_FIN] &&
      fif_cond(q.ent_cfg[0], FLAG_FIN) == COND_ZERO |-> !ent_hit[0];
  endproperty
  a_fin_zero: assert property (p_fin_zero)
    else $error("entry matched with forbidden fin");

  property p_syn_one;
    @(posedge clk) disable iff (!resetn)
      !frm_tcp_flags[FLAG_SYN] &&
      fif_cond(q.ent_cfg[0], FLAG_SYN) == COND_ONE |-> !ent_hit[0];
  endproperty
  a_syn_one: assert property (p_syn_one)
    else $error("entry matched without required syn");

  property p_rst_zero;
    @(posedge clk) disable iff (!resetn)
      frm_is_tcp && frm_tcp_flags[FLAG_RST] &&
      fif_cond(q.ent_cfg[0], FLAG_RST) == COND_ZERO |-> !ent_hit[0];
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("entry matched with forbidden rst");

  property p_psh_one;
    @(posedge clk) disable iff (!resetn)
      !frm_is_tcp &&
      fif_cond(q.ent_cfg[0], FLAG_PSH) == COND_ONE |-> !ent_hit[0];
  endproperty
  a_psh_one: assert property (p_psh_one)
    else $error("non-tcp frame matched a psh condition");

  property p_etype;
    @(posedge clk) disable iff (!resetn)
      q.ent_cfg[0][ENT_FTYPE_BIT] && q.ent_cfg[0][ENT_SPEC_BIT] &&
      frm_etype != q.ent_etype[0] |-> !ent_hit[0];
  endproperty
  a_etype: assert property (p_etype)
    else $error("entry matched a different ethertype");

  property p_default;
    @(posedge clk) disable iff (!resetn)
      frm_valid && int'(frm_port) < NUM_PORTS && ent_hit == '0 &&
      !q.port_dis[frm_port]
      |=> res_valid && !res_hit &&
          res_deny == $past(q.port_cfg[frm_port][PC_DENY_BIT]);
  endproperty
  a_default: assert property (p_default)
    else $error("port default not applied to unmatched frame");

  property p_group;
    @(posedge clk) disable iff (!resetn)
      res_valid |-> res_group >= 4'h1 && res_group <= 4'h8;
  endproperty
  a_group: assert property (p_group)
    else $error("policy group out of range");

  property p_shut;
    @(posedge clk) disable iff (!resetn)
      frm_valid && int'(frm_port) < NUM_PORTS &&
      q.port_cfg[frm_port][PC_SHUT_BIT] |=> port_dis[$past(frm_port)];
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown port not disabled after a frame");

  property p_count;
    @(posedge clk) disable iff (!resetn)
      frm_valid && int'(frm_port) < NUM_PORTS && ent_hit[0] &&
      !q.port_dis[frm_port] && !(reg_wr && reg_addr == A_CLEAR)
      |=> q.hit_cnt[0] == $past(q.hit_cnt[0]) + 1;
  endproperty
  a_count: assert property (p_count)
    else $error("hit counter did not step");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
      reg_wr && reg_addr == A_CLEAR && !frm_valid |=> q.hit_cnt == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("counters not cleared");
endmodule : fif_filter_top

// ### tb/fif_frame_src.sv
// Purpose: receive side of the switch ports, hands frame descriptors over
// Assumes: one descriptor per send call, valid for exactly one cycle
// Notes: after a frame the lines show the inverse of the last value so a
//   stale descriptor never looks valid by accident
module fif_frame_src (
  input wire logic clk, // clock, driven by the bench
  output logic frm_valid, // descriptor strobe
  output logic [fif_pkg::PORT_W-1:0] frm_port, // receiving port
  output logic frm_is_tcp, // tcp frame
  output logic [5:0] frm_tcp_flags, // tcp control flags
  output logic [15:0] frm_etype // ethertype of the frame
);
  timeunit 1ns;
  timeprecision 1ns;
  import fif_pkg::*;

  // quiet lines at time zero
  initial
  begin
    frm_valid = 1'b0;
    frm_port = '0;
    frm_is_tcp = 1'b0;
    frm_tcp_flags = '0;
    frm_etype = '0;
  end

  // one descriptor, then released lines
  task automatic send(input logic [3:0] p, input logic t,
                      input logic [5:0] f, input logic [15:0] e);
    @(posedge clk);
    frm_valid <= 1'b1;
    frm_port <= p;
    frm_is_tcp <= t;
    frm_tcp_flags <= f;
    frm_etype <= e;
    @(posedge clk);
    frm_valid <= 1'b0;
    frm_port <= ~p;
    frm_is_tcp <= ~t;
    frm_tcp_flags <= ~f;
    frm_etype <= ~e;
  endtask : send
endmodule : fif_frame_src

// ### tb/tb_top.sv
// Purpose: self-checking bench for the ingress frame filter
// Assumes: register reads answer in the next cycle, results one cycle late
// Notes: entry 0 tests flags, entry 1 ethertype; ports 3..5 policy tests
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fif_pkg::*;
  logic clk = 1'b0; // 10 MHz
  logic resetn = 1'b0; // active low reset
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic res_valid, res_hit, res_deny, res_copy_en, res_mirror, res_log;
  logic [ENT_W-1:0] res_entry;
  logic [3:0] res_group, res_rate;
  logic [PORT_W-1:0] res_copy_port;
  logic [NUM_PORTS-1:0] port_dis;
  // frame descriptor from the port model
  logic frm_valid;
  logic [PORT_W-1:0] frm_port;
  logic frm_is_tcp;
  logic [5:0] frm_tcp_flags;
  logic [15:0] frm_etype;
  int mismatches = 0;
  int checks = 0;

  always #50 clk = ~clk;

  fif_frame_src fif_frame_src_inst (.clk(clk), .frm_valid(frm_valid),
    .frm_port(frm_port), .frm_is_tcp(frm_is_tcp),
    .frm_tcp_flags(frm_tcp_flags), .frm_etype(frm_etype));

  fif_filter_top fif_filter_top_inst (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frm_valid(frm_valid),
    .frm_port(frm_port),
    .frm_is_tcp(frm_is_tcp),
    .frm_tcp_flags(frm_tcp_flags),
    .frm_etype(frm_etype),
    .res_valid(res_valid), .res_hit(res_hit), .res_entry(res_entry),
    .res_deny(res_deny), .res_group(res_group), .res_rate(res_rate),
    .res_copy_en(res_copy_en), .res_copy_port(res_copy_port),
    .res_mirror(res_mirror), .res_log(res_log), .port_dis(port_dis));

  ////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // closing of the run, also used by the watchdog
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd_chk

  // send a frame and stop mid-cycle where its result stands
  task automatic frame(input logic [3:0] p, input logic t,
                       input logic [5:0] f, input logic [15:0] e);
    fif_frame_src_inst.send(p, t, f, e);
    @(negedge clk);
  endtask : frame

  // frame result: valid, hit, entry and action
  task automatic res_chk(input logic h, input logic [1:0] en,
                         input logic d);
    chk({res_valid, res_hit, (h ? res_entry : 2'h0), res_deny},
        {1'b1, h, en, d});
  endtask : res_chk

  // entry config with flag k set to condition c, entry valid
  function automatic logic [15:0] flag_cfg(input int k,
                                           input logic [1:0] c);
    flag_cfg = (ENT_CFG_RST & ~(16'h0003 << (ENT_COND_LSB + 2 * k)))
      | (16'(c) << (ENT_COND_LSB + 2 * k)) | 16'h0001;
  endfunction : flag_cfg

  ////////////////////////////////////////////////////////////////////////
  // watchdog: all tests take just over a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // reset values of config words and an unmapped place
    rd_chk(A_ENT_CFG, 32'(ENT_CFG_RST));
    rd_chk(A_ENT_ETYPE, 32'(ENT_ETYPE_RST));
    rd_chk(A_PORT_CFG + 8'h03, 32'h00000000);
    rd_chk(8'h7F, 32'h00000000);
    frame(4'h3, 1'b0, 6'h00, 16'h1234);
    chk({res_group, res_deny, res_rate, res_copy_en, res_mirror, res_log},
        {4'h1, 1'b0, 4'h0, 1'b0, 1'b0, 1'b0});
    $display("test reset defaults done");
    // port 0 denies by default so an entry hit shows as an override
    wr(A_PORT_CFG, 32'h00002008);
    for (int k = 0; k < 6; k++)
    begin
      wr(A_ENT_CFG, 32'(flag_cfg(k, COND_ONE)));
      frame(4'h0, 1'b1, 6'(1 << k), 16'h0800);
      res_chk(1'b1, 2'h0, 1'b0);
      chk(res_mirror, 1'b0);
      frame(4'h0, 1'b1, 6'h00, 16'h0800);
      res_chk(1'b0, 2'h0, 1'b1);
      frame(4'h0, 1'b0, 6'(1 << k), 16'h0800);
      res_chk(1'b0, 2'h0, 1'b1);
      wr(A_ENT_CFG, 32'(flag_cfg(k, COND_ZERO)));
      frame(4'h0, 1'b1, 6'(1 << k), 16'h0800);
      res_chk(1'b0, 2'h0, 1'b1);
      frame(4'h0, 1'b1, ~6'(1 << k), 16'h0800);
      res_chk(1'b1, 2'h0, 1'b0);
    end
    rd_chk(A_ENT_CNT, 32'h0000000C);
    wr(A_CLEAR, 32'h00000000);
    rd_chk(A_ENT_CNT, 32'h00000000);
    $display("test flag conditions done");
    // ethertype class on entry 1, entry 0 off
    wr(A_ENT_CFG, 32'(ENT_CFG_RST));
    wr(A_ENT_CFG + 8'h01, 32'(ENT_CFG_RST | 16'h0007));
    wr(A_ENT_ETYPE + 8'h01, 32'h000088B5);
    frame(4'h0, 1'b0, 6'h00, 16'h88B5);
    res_chk(1'b1, 2'h1, 1'b0);
    frame(4'h0, 1'b0, 6'h00, 16'h88B6);
    res_chk(1'b0, 2'h0, 1'b1);
    wr(A_ENT_CFG + 8'h01, 32'(ENT_CFG_RST | 16'h0003));
    frame(4'h0, 1'b0, 6'h00, 16'h1234);
    res_chk(1'b1, 2'h1, 1'b0);
    frame(4'h0, 1'b0, 6'h00, 16'h86DD);
    res_chk(1'b0, 2'h0, 1'b1);
    wr(A_ENT_CFG + 8'h01, 32'(ENT_CFG_RST | 16'h0005));
    frame(4'h0, 1'b0, 6'h00, 16'h88B6);
    res_chk(1'b1, 2'h1, 1'b0);
    rd_chk(A_ENT_CNT + 8'h01, 32'h00000003);
    wr(A_ENT_CFG + 8'h01, 32'(ENT_CFG_RST));
    $display("test ethertype done");
    // port 3: group 8, deny, limiter 15, copy to port 9, mirror
    wr(A_PORT_CFG + 8'h03, 32'h000033FF);
    rd_chk(A_PORT_CFG + 8'h03, 32'h000033FF);
    frame(4'h3, 1'b0, 6'h00, 16'h1234);
    chk({res_group, res_deny, res_rate, res_copy_en, res_copy_port,
         res_mirror},
        {4'h8, 1'b1, 4'hF, 1'b1, 4'h9, 1'b1});
    frame(4'hC, 1'b0, 6'h00, 16'h1234);
    chk(res_valid, 1'b0);
    $display("test port policy done");
    // port 4 logs, limited to one frame per gap
    wr(A_PORT_CFG + 8'h04, 32'h00004000);
    frame(4'h4, 1'b0, 6'h00, 16'h1234);
    chk(res_log, 1'b1);
    frame(4'h4, 1'b0, 6'h00, 16'h1234);
    chk(res_log, 1'b0);
    repeat (LOG_GAP_CYC) @(posedge clk);
    frame(4'h4, 1'b0, 6'h00, 16'h1234);
    chk(res_log, 1'b1);
    $display("test logging done");
    // port 5 shuts down on its first frame
    wr(A_PORT_CFG + 8'h05, 32'h00008000);
    frame(4'h5, 1'b0, 6'h00, 16'h1234);
    res_chk(1'b0, 2'h0, 1'b0);
    rd_chk(A_PORT_DIS, 32'h00000020);
    frame(4'h5, 1'b0, 6'h00, 16'h1234);
    res_chk(1'b0, 2'h0, 1'b1);
    wr(A_PORT_DIS, 32'h00000020);
    rd_chk(A_PORT_DIS, 32'h00000000);
    chk(32'(port_dis), 32'h00000000);
    $display("test shutdown done");
    print_verdict();
  end
endmodule : tb_top
